// ===== design/pcsr_pkg.sv
package pcsr_pkg;

  // Serial frame layout: read flag, six address bits, one spare bit, 24 data bits.
  localparam int FRAME_BITS = 32;
  localparam int HEADER_LAST_IDX = 7;
  localparam int FRAME_LAST_IDX = 31;
  localparam int DATA_BITS = 24;

  // Register addresses as the host sends them on the serial port.
  localparam logic [5:0] ADDR_SLIP_GUARD_CONTROL = 6'h1c;
  localparam logic [5:0] ADDR_RESERVED_RW_A = 6'h1d;
  localparam logic [5:0] ADDR_TEMP_SENSOR_CONTROL = 6'h1e;
  localparam logic [5:0] ADDR_LOCK_SWEEP_STATUS = 6'h1f;
  localparam logic [5:0] ADDR_RESERVED_RO_B = 6'h20;
  localparam logic [5:0] ADDR_TEMP_SENSOR_READING = 6'h21;
  localparam logic [5:0] ADDR_RESERVED_RO_C = 6'h22;

  // Field positions.
  localparam int STEP_LSB = 0;
  localparam int STEP_MSB = 3;
  localparam int STEP_DIR_BIT = 3;
  localparam int FORCE_BIT = 4;
  localparam int MANUAL_RSTB_BIT = 5;
  localparam int TSENS_EN_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int OVF_LSB = 1;
  localparam int OVF_MSB = 3;
  localparam int SWEEP_BIT = 5;
  localparam int TEMP_MSB = 6;

  // Reset and fixed read values.
  localparam logic [3:0] STEP_RST = 4'h0;
  localparam logic FORCE_RST = 1'h0;
  localparam logic MANUAL_RSTB_RST = 1'h1;
  localparam logic TSENS_EN_RST = 1'h0;
  localparam logic [23:0] RESERVED_RW_A_RST = 24'h00_0000;
  localparam logic [23:0] RESERVED_RO_B_VAL = 24'h00_0020;
  localparam logic [23:0] RESERVED_RO_C_VAL = 24'h00_0000;
  localparam logic [6:0] TEMP_CODE_RST = 7'h00;
  localparam logic [6:0] TEMP_CODE_MAX = 7'h07;

  // Temperature arithmetic in tenths of a degree.
  localparam int TEMP_OFFSET_DECI = 400;
  localparam int TEMP_STEP_DECI = 175;
  localparam int TEMP_SAT_HI_DECI = 825;
  localparam int TEMP_SAT_LO_DECI = -225;

  // Cycles the detector flops are held in reset to realign after a correction.
  localparam int REALIGN_CYCLES = 1;

  typedef enum logic [1:0] {FRAME_IDLE, FRAME_HEADER, FRAME_DATA, FRAME_DONE} pcsr_frame_type;
  typedef enum logic [1:0] {SLIP_IDLE, SLIP_RUN, SLIP_REALIGN} pcsr_slip_type;

endpackage

// ===== design/pcsr_slip_if.sv
`timescale 1ns/10ps
interface pcsr_slip_if;
  logic [3:0] step;
  logic enable;
  logic cycle_event;
  logic detector_active;
  logic auto_reset_n;
  logic slip_strobe;
  logic slip_dir;
  logic busy;

  modport main (
    output step,
    output enable,
    output cycle_event,
    output detector_active,
    input auto_reset_n,
    input slip_strobe,
    input slip_dir,
    input busy
  );

  modport corrector (
    input step,
    input enable,
    input cycle_event,
    input detector_active,
    output auto_reset_n,
    output slip_strobe,
    output slip_dir,
    output busy
  );
endinterface

// ===== design/pcsr_slip_corrector.sv
`timescale 1ns/10ps
module pcsr_slip_corrector (
  input wire logic clock,
  input wire logic resetn,
  pcsr_slip_if.corrector s
);

  pcsr_pkg::pcsr_slip_type state_q;
  logic [2:0] remaining_q;
  logic dir_q;
  logic auto_reset_n_q;
  logic accept;

  // A correction starts only when enabled, the detector is out of reset and a full cycle is seen.
  assign accept = s.enable && s.cycle_event && s.detector_active
                  && (s.step[2:0] != 3'h0);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= pcsr_pkg::SLIP_IDLE;
    end else begin
      case (state_q)
        pcsr_pkg::SLIP_IDLE: begin
          if (accept) begin
            state_q <= pcsr_pkg::SLIP_RUN;
          end
        end
        pcsr_pkg::SLIP_RUN: begin
          // A forced detector reset aborts the correction at once.
          if (!s.detector_active) begin
            state_q <= pcsr_pkg::SLIP_IDLE;
          end else if (remaining_q == 3'h1) begin
            state_q <= pcsr_pkg::SLIP_REALIGN;
          end
        end
        default: begin
          state_q <= pcsr_pkg::SLIP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      remaining_q <= 3'h0;
      dir_q <= 1'h0;
    end else if (state_q == pcsr_pkg::SLIP_IDLE && accept) begin
      remaining_q <= s.step[2:0];
      dir_q <= s.step[pcsr_pkg::STEP_DIR_BIT];
    end else if (s.slip_strobe) begin
      remaining_q <= remaining_q - 3'h1;
    end
  end

  // The automatic reset pulses low for one realign cycle after the last slip step.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      auto_reset_n_q <= 1'h1;
    end else begin
      auto_reset_n_q <= !(state_q == pcsr_pkg::SLIP_RUN && s.detector_active
                          && remaining_q == 3'h1);
    end
  end

  assign s.slip_strobe = (state_q == pcsr_pkg::SLIP_RUN) && s.detector_active;
  assign s.slip_dir = dir_q;
  assign s.auto_reset_n = auto_reset_n_q;
  assign s.busy = (state_q != pcsr_pkg::SLIP_IDLE);

endmodule

// ===== design/pcsr_regs.sv
// How it works
// - Step field zero turns the cycle-slip guard off completely.
// - Nonzero step slips the detector by the programmed count per full-cycle error.
// - Top step bit gives direction; slips happen only while detector reset releases.
// - Override set: detector reset follows manual bit; clear: guard logic drives it.
// - Detector held in reset tristates the charge pump, opening the loop.
// - Manual reset bit resets to one; guard needs it and the global enable.
// - Status bit 0 reads one while locked, zero while unlocked.
// - Status bits 3 to 1 read one when the modulator overflowed.
// - Status bit 5 reads one while a sweep ramp runs.
// - Temperature code is floor((temperature plus 40) / 17.5).
// - Code saturates at seven from 82.5 up and zero from -22.5 down.
// - Reserved word at 1D is writable, resets to zero.
// - Reserved word at 20 is read-only and reads hex 20.
// - Reserved word at 22 is read-only and reads zero.
`timescale 1ns/10ps
module pcsr_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic serial_enable,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  input wire logic csp_global_enable,
  input wire logic phase_full_cycle,
  input wire logic lock_flag,
  input wire logic [2:0] modulator_overflow_flags,
  input wire logic sweep_active_flag,
  input wire logic tsens_sample_strobe,
  input wire logic signed [11:0] tsens_temp_deci,
  output logic tsens_enable,
  output logic pfd_reset_n,
  output logic charge_pump_tristate,
  output logic slip_strobe,
  output logic slip_direction
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [3:0] slip_guard_step_q;
  logic force_q;
  logic manual_rstb_q;
  logic [23:0] reserved_rw_a_q;
  logic tsens_enable_q;
  logic [6:0] temp_code_q;
  logic pfd_reset_n_q;
  logic charge_pump_tristate_q;
  logic serial_data_out_q;
  logic serial_data_out_en_q;

  // Serial port state.
  pcsr_pkg::pcsr_frame_type frame_q;
  logic serial_clock_q;
  logic sck_rise;
  logic sck_fall;
  logic [5:0] bit_cnt_q;
  logic [30:0] shift_in_q;
  logic rw_q;
  logic [5:0] addr_q;
  logic [23:0] rd_shift_q;
  logic [7:0] header_word;
  logic [23:0] write_word;
  logic header_done;
  logic frame_write;
  logic [23:0] read_word;

  logic slip_guard_enable;
  logic pfd_reset_n_d;

  pcsr_slip_if slip ();

  ////////////////////////////////////////////////////////////////////////////////
  // Temperature conversion without a divider: compare against each code threshold.

  function automatic logic [6:0] temp_to_code(input logic signed [11:0] t);
    logic [6:0] code;
    int ti;
    code = pcsr_pkg::TEMP_CODE_RST;
    ti = int'(t);
    if (ti >= pcsr_pkg::TEMP_SAT_HI_DECI) begin
      code = pcsr_pkg::TEMP_CODE_MAX;
    end else if (ti > pcsr_pkg::TEMP_SAT_LO_DECI) begin
      for (int k = 1; k < 7; k++) begin
        if (ti >= k * pcsr_pkg::TEMP_STEP_DECI - pcsr_pkg::TEMP_OFFSET_DECI) begin
          code = 7'(k);
        end
      end
    end
    return code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame capture. The serial pins are synchronous to clock, so edges are found
  // by comparing with the previous sample.

  assign sck_rise = serial_clock && !serial_clock_q;
  assign sck_fall = !serial_clock && serial_clock_q;
  assign header_word = {shift_in_q[6:0], serial_data_in};
  assign write_word = {shift_in_q[22:0], serial_data_in};
  assign header_done = (frame_q == pcsr_pkg::FRAME_HEADER) && sck_rise
                       && (bit_cnt_q == 6'(pcsr_pkg::HEADER_LAST_IDX));
  assign frame_write = (frame_q == pcsr_pkg::FRAME_DATA) && sck_rise && !rw_q
                       && (bit_cnt_q == 6'(pcsr_pkg::FRAME_LAST_IDX));

  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_clock_q <= 1'h0;
    end else begin
      serial_clock_q <= serial_clock;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      frame_q <= pcsr_pkg::FRAME_IDLE;
    end else if (!serial_enable) begin
      frame_q <= pcsr_pkg::FRAME_IDLE;
    end else begin
      case (frame_q)
        pcsr_pkg::FRAME_IDLE: begin
          frame_q <= pcsr_pkg::FRAME_HEADER;
        end
        pcsr_pkg::FRAME_HEADER: begin
          if (header_done) begin
            frame_q <= pcsr_pkg::FRAME_DATA;
          end
        end
        pcsr_pkg::FRAME_DATA: begin
          if (sck_rise && bit_cnt_q == 6'(pcsr_pkg::FRAME_LAST_IDX)) begin
            frame_q <= pcsr_pkg::FRAME_DONE;
          end
        end
        default: begin
          frame_q <= pcsr_pkg::FRAME_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !serial_enable) begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 31'h0000_0000;
    end else if (sck_rise && frame_q != pcsr_pkg::FRAME_DONE) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
      shift_in_q <= {shift_in_q[29:0], serial_data_in};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rw_q <= 1'h0;
      addr_q <= 6'h00;
    end else if (header_done) begin
      rw_q <= header_word[7];
      addr_q <= header_word[6:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode. Status and reading words are sampled live at the end of the header.

  always_comb begin
    read_word = 24'h00_0000;
    if (header_word[6:1] == pcsr_pkg::ADDR_SLIP_GUARD_CONTROL) begin
      read_word[pcsr_pkg::STEP_MSB:pcsr_pkg::STEP_LSB] = slip_guard_step_q;
      read_word[pcsr_pkg::FORCE_BIT] = force_q;
      read_word[pcsr_pkg::MANUAL_RSTB_BIT] = manual_rstb_q;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_RESERVED_RW_A) begin
      read_word = reserved_rw_a_q;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_TEMP_SENSOR_CONTROL) begin
      read_word[pcsr_pkg::TSENS_EN_BIT] = tsens_enable_q;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_LOCK_SWEEP_STATUS) begin
      read_word[pcsr_pkg::LOCK_BIT] = lock_flag;
      read_word[pcsr_pkg::OVF_MSB:pcsr_pkg::OVF_LSB] = modulator_overflow_flags;
      read_word[pcsr_pkg::SWEEP_BIT] = sweep_active_flag;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_RESERVED_RO_B) begin
      read_word = pcsr_pkg::RESERVED_RO_B_VAL;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_TEMP_SENSOR_READING) begin
      read_word[pcsr_pkg::TEMP_MSB:0] = temp_code_q;
    end else if (header_word[6:1] == pcsr_pkg::ADDR_RESERVED_RO_C) begin
      read_word = pcsr_pkg::RESERVED_RO_C_VAL;
    end
  end

  // Read data leave on falling edges so the host can sample them on the next rising edge.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_shift_q <= 24'h00_0000;
      serial_data_out_q <= 1'h0;
    end else if (header_done) begin
      rd_shift_q <= read_word;
    end else if (frame_q == pcsr_pkg::FRAME_DATA && rw_q && sck_fall) begin
      serial_data_out_q <= rd_shift_q[pcsr_pkg::DATA_BITS - 1];
      rd_shift_q <= {rd_shift_q[22:0], 1'h0};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_data_out_en_q <= 1'h0;
    end else begin
      serial_data_out_en_q <= serial_enable && frame_q == pcsr_pkg::FRAME_DATA && rw_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writes commit only at the last data bit, so a frame cut short changes nothing.
  // Writes to read-only or unmapped addresses are dropped.

  always_ff @(posedge clock) begin
    if (!resetn) begin
      slip_guard_step_q <= pcsr_pkg::STEP_RST;
      force_q <= pcsr_pkg::FORCE_RST;
      manual_rstb_q <= pcsr_pkg::MANUAL_RSTB_RST;
    end else if (frame_write && addr_q == pcsr_pkg::ADDR_SLIP_GUARD_CONTROL) begin
      slip_guard_step_q <= write_word[pcsr_pkg::STEP_MSB:pcsr_pkg::STEP_LSB];
      force_q <= write_word[pcsr_pkg::FORCE_BIT];
      manual_rstb_q <= write_word[pcsr_pkg::MANUAL_RSTB_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      reserved_rw_a_q <= pcsr_pkg::RESERVED_RW_A_RST;
    end else if (frame_write && addr_q == pcsr_pkg::ADDR_RESERVED_RW_A) begin
      reserved_rw_a_q <= write_word;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tsens_enable_q <= pcsr_pkg::TSENS_EN_RST;
    end else if (frame_write && addr_q == pcsr_pkg::ADDR_TEMP_SENSOR_CONTROL) begin
      tsens_enable_q <= write_word[pcsr_pkg::TSENS_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Temperature measurement. A sample taken while the sensor is off is ignored, and
  // the reading keeps its last value; reads never disturb it.

  always_ff @(posedge clock) begin
    if (!resetn) begin
      temp_code_q <= pcsr_pkg::TEMP_CODE_RST;
    end else if (tsens_enable_q && tsens_sample_strobe) begin
      temp_code_q <= temp_to_code(tsens_temp_deci);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle-slip guard and detector reset.

  assign slip_guard_enable = (slip_guard_step_q != 4'h0) && manual_rstb_q
                             && csp_global_enable;
  assign pfd_reset_n_d = force_q ? manual_rstb_q : slip.auto_reset_n;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pfd_reset_n_q <= 1'h1;
      charge_pump_tristate_q <= 1'h0;
    end else begin
      pfd_reset_n_q <= pfd_reset_n_d;
      charge_pump_tristate_q <= !pfd_reset_n_d;
    end
  end

  assign slip.step = slip_guard_step_q;
  assign slip.enable = slip_guard_enable;
  assign slip.cycle_event = phase_full_cycle;
  assign slip.detector_active = pfd_reset_n_q;

  pcsr_slip_corrector u_corrector (
    .clock(clock),
    .resetn(resetn),
    .s(slip.corrector)
  );

  assign tsens_enable = tsens_enable_q;
  assign pfd_reset_n = pfd_reset_n_q;
  assign charge_pump_tristate = charge_pump_tristate_q;
  assign slip_strobe = slip.slip_strobe;
  assign slip_direction = slip.slip_dir;
  assign serial_data_out = serial_data_out_q;
  assign serial_data_out_en = serial_data_out_en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_event_taken;
    slip_guard_enable && phase_full_cycle && pfd_reset_n_q && !slip.busy
    && slip_guard_step_q[2:0] != 3'h0;
  endsequence

  sequence s_first_slip;
    ##1 slip_strobe && slip_direction == $past(slip_guard_step_q[3]);
  endsequence

  a_step_zero_off: assert property (slip_guard_step_q == 4'h0 |-> !slip.busy [*2])
    else $error("slip guard active with zero step");

  a_slip_starts: assert property (s_event_taken |-> s_first_slip)
    else $error("no slip step after accepted full-cycle event");

  a_slip_needs_rstb: assert property (slip_strobe |-> pfd_reset_n_q)
    else $error("slip step while detector held in reset");

  a_force_manual: assert property (
      force_q && $stable(force_q) && $stable(manual_rstb_q)
      |=> pfd_reset_n == $past(manual_rstb_q))
    else $error("forced detector reset does not follow manual bit");

  // The pump output is registered with the detector reset, so they must agree every cycle.
  a_cp_tristate: assert property (charge_pump_tristate == !pfd_reset_n)
    else $error("charge pump driven while detector in reset");

  a_guard_enable: assert property (
      !manual_rstb_q || !csp_global_enable |-> !slip_guard_enable)
    else $error("guard enabled without manual bit and global enable");

  a_status_read: assert property (
      header_done && header_word[6:1] == pcsr_pkg::ADDR_LOCK_SWEEP_STATUS
      |=> rd_shift_q[0] == $past(lock_flag)
      && rd_shift_q[3:1] == $past(modulator_overflow_flags)
      && rd_shift_q[5] == $past(sweep_active_flag))
    else $error("status read does not show live lock, overflow and sweep flags");

  a_temp_saturate: assert property (
      tsens_enable_q && tsens_sample_strobe && tsens_temp_deci >= 12'sd825
      |=> temp_code_q == pcsr_pkg::TEMP_CODE_MAX)
    else $error("temperature code not saturated high");

  a_rsvd_b_read: assert property (
      header_done && header_word[6:1] == pcsr_pkg::ADDR_RESERVED_RO_B
      |=> rd_shift_q == 24'h00_0020)
    else $error("reserved word at 20 reads wrong value");

  a_read_no_clear: assert property (
      header_done && !tsens_sample_strobe |=> $stable(temp_code_q))
    else $error("reading a register altered the temperature code");

endmodule

// ===== tb/pcsr_host.sv
`timescale 1ns/10ps
module pcsr_host (
  input wire logic clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  output logic serial_clock,
  output logic serial_enable,
  output logic serial_data_in
);
  initial begin
    serial_clock = 1'b0;
    serial_enable = 1'b0;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // One whole 32-bit frame; the clock stands low outside frames.
  task automatic xfer(input logic rd, input logic [5:0] addr, input logic [23:0] wdata,
                      output logic [23:0] rdata, output logic en_ok);
    logic [31:0] f;
    f = {rd, addr, 1'b0, wdata};
    rdata = 24'h00_0000;
    en_ok = 1'b1;
    @(negedge clock);
    serial_enable = 1'b1;
    for (int k = 0; k < 32; k++) begin
      serial_clock = 1'b0;
      serial_data_in = f[31-k];
      // Four cycles low leave time for the edge detect and the output register.
      repeat (4) @(negedge clock);
      if (k >= 8) begin
        rdata[31-k] = serial_data_out;
        en_ok = en_ok & serial_data_out_en;
      end
      serial_clock = 1'b1;
      repeat (3) @(negedge clock);
    end
    serial_clock = 1'b0;
    repeat (3) @(negedge clock);
    serial_enable = 1'b0;
    // A released data line must not keep showing the last bit.
    serial_data_in = ~serial_data_in;
    repeat (2) @(negedge clock);
  endtask
endmodule

// ===== tb/pcsr_regs_tb.sv
`timescale 1ns/10ps
module pcsr_regs_tb;
  logic clock, resetn, serial_clock, serial_enable, serial_data_in;
  logic serial_data_out, serial_data_out_en, csp_global_enable, phase_full_cycle;
  logic lock_flag, sweep_active_flag, tsens_sample_strobe;
  logic [2:0] modulator_overflow_flags;
  logic signed [11:0] tsens_temp_deci;
  logic tsens_enable, pfd_reset_n, charge_pump_tristate, slip_strobe, slip_direction;
  logic [23:0] rd;
  logic en_ok;
  logic [5:0] pats [3] = '{6'h3f, 6'h12, 6'h21};
  int temps [9] = '{-400, -225, -224, 0, 649, 650, 824, 825, 1500};
  int num_errors = 0;
  int tests_run = 0;
  int e;

  pcsr_regs u_pcsr_regs (.clock, .resetn, .serial_clock, .serial_enable, .serial_data_in,
    .serial_data_out, .serial_data_out_en, .csp_global_enable, .phase_full_cycle,
    .lock_flag, .modulator_overflow_flags, .sweep_active_flag, .tsens_sample_strobe,
    .tsens_temp_deci, .tsens_enable, .pfd_reset_n, .charge_pump_tristate, .slip_strobe,
    .slip_direction);
  pcsr_host u_pcsr_host (.clock, .serial_data_out, .serial_data_out_en, .serial_clock,
    .serial_enable, .serial_data_in);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_pcsr_host.xfer(1'b0, a, d, rd, en_ok);
  endtask

  // Read frames carry all ones in their data bits, which the device must ignore.
  task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
    u_pcsr_host.xfer(1'b1, a, 24'hff_ffff, rd, en_ok);
    check($sformatf("reg %h", a), rd, exp);
    check("read enable", {23'h0, en_ok}, 24'h00_0001);
  endtask

  task automatic slip(input logic [7:0] ctl, input logic g, input int n, input int lows,
                      input logic dir);
    int s, l, t;
    s = 0;
    l = 0;
    t = 0;
    wr(6'h1c, {16'h0000, ctl});
    csp_global_enable = g;
    @(negedge clock);
    phase_full_cycle = 1'b1;
    @(negedge clock);
    phase_full_cycle = 1'b0;
    repeat (14) begin
      if (slip_strobe === 1'b1) begin
        s++;
        if (slip_direction !== dir) t++;
      end
      if (pfd_reset_n === 1'b0) l++;
      if (charge_pump_tristate !== ~pfd_reset_n) t++;
      @(negedge clock);
    end
    check("slip steps", 24'(s), 24'(n));
    check("detector resets", 24'(l), 24'(lows));
    check("direction or pump", 24'(t), 24'h00_0000);
  endtask

  task automatic pulse();
    tsens_sample_strobe = 1'b1;
    @(negedge clock);
    tsens_sample_strobe = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    $display("unexpected watchdog: run did not finish");
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    csp_global_enable = 1'b0;
    phase_full_cycle = 1'b0;
    lock_flag = 1'b0;
    modulator_overflow_flags = 3'h0;
    sweep_active_flag = 1'b0;
    tsens_sample_strobe = 1'b0;
    tsens_temp_deci = 12'h000;
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    check("detector reset", {23'h0, pfd_reset_n}, 24'h00_0001);
    rdchk(6'h1c, 24'h00_0020);
    rdchk(6'h1d, 24'h00_0000);
    rdchk(6'h1e, 24'h00_0000);
    rdchk(6'h20, 24'h00_0020);
    rdchk(6'h21, 24'h00_0000);
    rdchk(6'h22, 24'h00_0000);
    rdchk(6'h3f, 24'h00_0000);
    $display("test defaults done");
    wr(6'h1d, 24'ha5_5a3c);
    rdchk(6'h1d, 24'ha5_5a3c);
    wr(6'h20, 24'hff_ffff);
    wr(6'h22, 24'hff_ffff);
    wr(6'h1f, 24'hff_ffff);
    rdchk(6'h20, 24'h00_0020);
    rdchk(6'h22, 24'h00_0000);
    resetn = 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    rdchk(6'h1d, 24'h00_0000);
    $display("test writes done");
    foreach (pats[i]) begin
      lock_flag = pats[i][0];
      modulator_overflow_flags = pats[i][3:1];
      sweep_active_flag = pats[i][5];
      rdchk(6'h1f, {18'h0, pats[i][5], 1'b0, pats[i][3:0]});
      rdchk(6'h1f, {18'h0, pats[i][5], 1'b0, pats[i][3:0]});
    end
    $display("test status done");
    wr(6'h1e, 24'h00_0001);
    check("sensor enable", {23'h0, tsens_enable}, 24'h00_0001);
    rdchk(6'h1e, 24'h00_0001);
    foreach (temps[i]) begin
      tsens_temp_deci = 12'(temps[i]);
      pulse();
      e = temps[i] >= 825 ? 7 : temps[i] <= -225 ? 0 : (temps[i] + 400) / 175;
      rdchk(6'h21, 24'(e));
    end
    wr(6'h1e, 24'h00_0000);
    check("sensor enable", {23'h0, tsens_enable}, 24'h00_0000);
    tsens_temp_deci = 12'h000;
    pulse();
    rdchk(6'h21, 24'h00_0007);
    $display("test temperature done");
    slip(8'h20, 1'b1, 0, 0, 1'b0);
    slip(8'h23, 1'b1, 3, 1, 1'b0);
    slip(8'h2b, 1'b1, 3, 1, 1'b1);
    slip(8'h21, 1'b1, 1, 1, 1'b0);
    slip(8'h27, 1'b1, 7, 1, 1'b0);
    slip(8'h23, 1'b0, 0, 0, 1'b0);
    slip(8'h03, 1'b1, 0, 0, 1'b0);
    slip(8'h13, 1'b1, 0, 14, 1'b0);
    slip(8'h33, 1'b1, 3, 0, 1'b0);
    wr(6'h1c, 24'h00_0020);
    rdchk(6'h1c, 24'h00_0020);
    $display("test slip done");
    wrap_up();
  end
endmodule
